/* include/adc_monitor_pkg.sv */
/*
  Constants, register map, field layout and carrier types shared by the
  channel monitor and its averaging stage.
  Assumes a single 250 MHz core clock and a serial front end that delivers
  register accesses as one-cycle strobes on that same clock.
*/
// Summary of operation
// - Input results are straight binary ten-bit codes
// - High limit uses greater-than, low uses less-or-equal
// - Limits are eight bits, results ten bits
// - Unmasked input violation sets flag in status A
// - Any unmasked flag drives interrupt at chosen polarity
// - Single mode repeats the channel select field
// - Scan order: supply, internal, external or inputs, three, four
// - Temperature results checked against own limits, flags
// - Temperatures are two's complement, quarter degree steps
// - Averaging takes sixteen samples before value update
// - Control B bit five disables averaging, default on
// - Scan runs continuously, internal temperature every pass, external only when the shared pins select the sensor
// - Serial traffic aborts conversion, restarts when finished
// - Supply low bits at 03h, high bits at 06h
// - Supply violation sets status B flag, interrupt
// - Supply conversion always uses internal reference
// - After reset scanning mode, conversions wait for enable
// - Control A bits one, two choose shared pin use
// - Control B bit four selects single-channel mode
package adc_monitor_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int LIM_W = 8;
  localparam int CH_W = 3;
  localparam int NUM_CH = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_A = 8'h00;
  localparam logic [7:0] OFS_STATUS_B = 8'h01;
  localparam logic [7:0] OFS_SUPPLY_LO = 8'h03;
  localparam logic [7:0] OFS_TEMP_LO = 8'h04;
  localparam logic [7:0] OFS_INPUT_LO = 8'h05;
  localparam logic [7:0] OFS_SUPPLY_HI = 8'h06;
  localparam logic [7:0] OFS_VALUE_BASE = 8'h07;
  localparam logic [7:0] OFS_CTRL_A = 8'h18;
  localparam logic [7:0] OFS_CTRL_B = 8'h19;
  localparam logic [7:0] OFS_MASK_A = 8'h1C;
  localparam logic [7:0] OFS_MASK_B = 8'h1D;
  localparam logic [7:0] OFS_LIMIT_BASE = 8'h2C;
  localparam logic [7:0] OFS_LIMIT_LAST = 8'h39;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRLA_EN_BIT = 0;
  localparam int CTRLA_PIN_LSB = 1;
  localparam int CTRLA_POL_BIT = 3;
  localparam int CTRLA_AINREF_BIT = 4;
  localparam int CTRLB_SEL_LSB = 0;
  localparam int CTRLB_SINGLE_BIT = 4;
  localparam int CTRLB_AVGOFF_BIT = 5;
  localparam logic [1:0] PIN_EXT_SENSOR = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TEMP_HI_RST = 8'h7F;
  localparam logic [7:0] TEMP_LO_RST = 8'h80;
  localparam logic [7:0] VOLT_HI_RST = 8'hFF;
  localparam logic [7:0] VOLT_LO_RST = 8'h00;

  // ----------------------------------------------------------------
  // Channel codes, equal to the select field and to the flag index
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_SUPPLY = 3'h0;
  localparam logic [2:0] CH_INT = 3'h1;
  localparam logic [2:0] CH_EXT = 3'h2;
  localparam logic [2:0] CH_AIN1 = 3'h3;
  localparam logic [2:0] CH_AIN2 = 3'h4;
  localparam logic [2:0] CH_AIN3 = 3'h5;
  localparam logic [2:0] CH_AIN4 = 3'h6;

  // ----------------------------------------------------------------
  // Averaging and timing
  // ----------------------------------------------------------------
  localparam int AVG_SAMPLES = 16;
  localparam int AVG_SHIFT = 4;
  localparam real CLK_FREQ_MHZ = 250.0;
  localparam real INT_AVG_TIME_MS = 25.92;
  localparam real EXT_AVG_TIME_MS = 16.8;
  localparam int INT_AVG_CYCLES = int'($floor(INT_AVG_TIME_MS * 1.0e3 * CLK_FREQ_MHZ));
  localparam int EXT_AVG_CYCLES = int'($floor(EXT_AVG_TIME_MS * 1.0e3 * CLK_FREQ_MHZ));

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_access_s;

  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] channel;
    logic intRef;
  } adc_req_s;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_SETTLE} seq_e;

endpackage : adc_monitor_pkg

/* design/sample_averager.sv */
/*
  Sixteen-sample averaging stage for converter results.
  Assumes one sample strobe per finished conversion on the core clock;
  clear discards a partial sum at once.
*/
`timescale 1ns/1ps
module sample_averager #(
  parameter int RES_W = adc_monitor_pkg::RES_W,
  parameter int AVG_SHIFT = adc_monitor_pkg::AVG_SHIFT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic avgOn,
  input wire logic isSigned,
  input wire logic sampleValid,
  input wire logic [RES_W-1:0] sample,
  output logic resultValid,
  output logic [RES_W-1:0] result
);

  localparam int SUM_W = RES_W + AVG_SHIFT;
  localparam logic [AVG_SHIFT-1:0] LAST_CNT = AVG_SHIFT'((1 << AVG_SHIFT) - 1);

  typedef struct packed {
    logic [SUM_W-1:0] sum;
    logic [AVG_SHIFT-1:0] cnt;
    logic valid;
    logic [RES_W-1:0] result;
  } avg_state_s;

  avg_state_s s_q;
  avg_state_s s_d;
  logic [SUM_W-1:0] extSample;
  logic [SUM_W-1:0] total;

  // Sign extension keeps negative temperatures averaging correctly
  assign extSample = isSigned ? {{AVG_SHIFT{sample[RES_W-1]}}, sample}
                              : {{AVG_SHIFT{1'b0}}, sample};
  assign total = s_q.sum + extSample;

  // Accumulate, then divide by shifting; valid is a one-cycle pulse
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (clear) begin
      s_d.sum = '0;
      s_d.cnt = '0;
    end else if (sampleValid) begin
      if (!avgOn) begin
        s_d.result = sample;
        s_d.valid = 1'b1;
        s_d.sum = '0;
        s_d.cnt = '0;
      end else if (s_q.cnt == LAST_CNT) begin
        s_d.result = total[SUM_W-1:AVG_SHIFT];
        s_d.valid = 1'b1;
        s_d.sum = '0;
        s_d.cnt = '0;
      end else begin
        s_d.sum = total;
        s_d.cnt = s_q.cnt + AVG_SHIFT'(1);
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign resultValid = s_q.valid;
  assign result = s_q.result;

  a_avg_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !avgOn && sampleValid && !clear |=> resultValid && result == $past(sample))
    else $error("unaveraged sample not passed through");

  a_avg_sixteen: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && avgOn && sampleValid && !clear && s_q.cnt != LAST_CNT |=> !resultValid)
    else $error("average produced before sixteen samples");

endmodule : sample_averager

/* design/adc_channel_monitor.sv */
/*
  Measurement sequencer and limit checker for a ten-bit monitoring converter.
  Assumes the serial front end presents register accesses as one-cycle
  strobes and holds commActive high for a whole transaction, and that the
  analog front end answers each start pulse with one convDone pulse.
*/
`timescale 1ns/1ps
module adc_channel_monitor #(
  parameter int INT_TIMEOUT_CYCLES = adc_monitor_pkg::INT_AVG_CYCLES,
  parameter int EXT_TIMEOUT_CYCLES = adc_monitor_pkg::EXT_AVG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire adc_monitor_pkg::reg_access_s regAccess,
  input wire logic commActive,
  output logic [7:0] regRdData,
  output adc_monitor_pkg::adc_req_s adcReq,
  input wire logic convDone,
  input wire logic [9:0] convResult,
  output logic irqOut
);

  localparam int MAX_TO = (INT_TIMEOUT_CYCLES > EXT_TIMEOUT_CYCLES) ?
                          INT_TIMEOUT_CYCLES : EXT_TIMEOUT_CYCLES;
  localparam int TMR_W = $clog2(MAX_TO + 1);
  localparam logic [TMR_W-1:0] INT_TO = TMR_W'(INT_TIMEOUT_CYCLES);
  localparam logic [TMR_W-1:0] EXT_TO = TMR_W'(EXT_TIMEOUT_CYCLES);

  typedef struct packed {
    adc_monitor_pkg::seq_e seq;
    logic [TMR_W-1:0] timer;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] maskA;
    logic [7:0] maskB;
    logic [6:0] flags;
    logic [6:0][9:0] results;
    logic [6:0][7:0] limHi;
    logic [6:0][7:0] limLo;
    logic [7:0] rdData;
    adc_monitor_pkg::adc_req_s req;
    logic irqPin;
  } mon_state_s;

  mon_state_s s_q;
  mon_state_s s_d;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic enable;
  logic single;
  logic extMode;
  logic polHigh;
  logic avgOn;
  logic [2:0] sel;
  logic [6:0] maskVec;
  logic anyUnmasked;
  logic avgClear;
  logic avgValid;
  logic [9:0] avgResult;
  logic isTemp;
  logic [7:0] coarse;
  logic hiOut;
  logic loOut;
  logic store;
  logic timeout;
  logic [TMR_W-1:0] toLimit;
  logic [2:0] nextCh;

  assign enable = s_q.ctrlA[adc_monitor_pkg::CTRLA_EN_BIT];
  assign extMode = s_q.ctrlA[adc_monitor_pkg::CTRLA_PIN_LSB +: 2]
                   == adc_monitor_pkg::PIN_EXT_SENSOR;
  assign polHigh = s_q.ctrlA[adc_monitor_pkg::CTRLA_POL_BIT];
  assign single = s_q.ctrlB[adc_monitor_pkg::CTRLB_SINGLE_BIT];
  assign avgOn = !s_q.ctrlB[adc_monitor_pkg::CTRLB_AVGOFF_BIT];
  // Codes above the last input fall back to the supply channel
  assign sel = (s_q.ctrlB[adc_monitor_pkg::CTRLB_SEL_LSB +: 3] > adc_monitor_pkg::CH_AIN4) ?
               adc_monitor_pkg::CH_SUPPLY : s_q.ctrlB[adc_monitor_pkg::CTRLB_SEL_LSB +: 3];
  assign maskVec = {s_q.maskA[5:0], s_q.maskB[0]};
  assign anyUnmasked = |(s_q.flags & ~maskVec);

  // ----------------------------------------------------------------
  // Limit comparison on the finished average
  // ----------------------------------------------------------------
  // Limits hold eight bits, so they meet the upper eight result bits
  assign isTemp = (s_q.req.channel == adc_monitor_pkg::CH_INT) ||
                  (s_q.req.channel == adc_monitor_pkg::CH_EXT);
  assign coarse = avgResult[9:2];
  always_comb begin
    if (isTemp) begin
      hiOut = $signed(coarse) > $signed(s_q.limHi[s_q.req.channel]);
      loOut = $signed(coarse) <= $signed(s_q.limLo[s_q.req.channel]);
    end else begin
      hiOut = coarse > s_q.limHi[s_q.req.channel];
      loOut = coarse <= s_q.limLo[s_q.req.channel];
    end
  end

  assign store = (s_q.seq == adc_monitor_pkg::SEQ_SETTLE) && avgValid;
  assign toLimit = (s_q.req.channel == adc_monitor_pkg::CH_EXT) ? EXT_TO : INT_TO;
  // A front end that never answers must not stall the scan forever
  assign timeout = (s_q.seq == adc_monitor_pkg::SEQ_WAIT) && (s_q.timer >= toLimit);
  assign avgClear = commActive || !enable || timeout;

  // ----------------------------------------------------------------
  // Channel stepping
  // ----------------------------------------------------------------
  always_comb begin
    if (single) begin
      nextCh = sel;
    end else begin
      case (s_q.req.channel)
        adc_monitor_pkg::CH_SUPPLY: nextCh = adc_monitor_pkg::CH_INT;
        adc_monitor_pkg::CH_INT: nextCh = extMode ? adc_monitor_pkg::CH_EXT
                                                   : adc_monitor_pkg::CH_AIN1;
        adc_monitor_pkg::CH_EXT: nextCh = adc_monitor_pkg::CH_AIN3;
        adc_monitor_pkg::CH_AIN1: nextCh = adc_monitor_pkg::CH_AIN2;
        adc_monitor_pkg::CH_AIN2: nextCh = adc_monitor_pkg::CH_AIN3;
        adc_monitor_pkg::CH_AIN3: nextCh = adc_monitor_pkg::CH_AIN4;
        default: nextCh = adc_monitor_pkg::CH_SUPPLY;
      endcase
    end
  end

  sample_averager u_avg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(avgClear),
    .avgOn(avgOn),
    .isSigned(isTemp),
    .sampleValid(convDone && (s_q.seq == adc_monitor_pkg::SEQ_WAIT) && !avgClear),
    .sample(convResult),
    .resultValid(avgValid),
    .result(avgResult)
  );

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------
  // Temperature limits start at the signed extremes and voltage limits at full
  // range, so only a reading whose upper eight bits are 00h (80h for temperatures) flags before the host programs its own limits.
  // A constant image keeps the asynchronous reset branch free of logic.
  localparam mon_state_s RESET_STATE = '{
    seq: adc_monitor_pkg::SEQ_IDLE,
    ctrlA: adc_monitor_pkg::CTRL_A_RST,
    ctrlB: adc_monitor_pkg::CTRL_B_RST,
    maskA: adc_monitor_pkg::MASK_RST,
    maskB: adc_monitor_pkg::MASK_RST,
    limHi: {{4{adc_monitor_pkg::VOLT_HI_RST}}, {2{adc_monitor_pkg::TEMP_HI_RST}},
            adc_monitor_pkg::VOLT_HI_RST},
    limLo: {{4{adc_monitor_pkg::VOLT_LO_RST}}, {2{adc_monitor_pkg::TEMP_LO_RST}},
            adc_monitor_pkg::VOLT_LO_RST},
    irqPin: 1'b1,
    default: '0
  };

  // ----------------------------------------------------------------
  // Next state: sequencer, register file, flags, interrupt pin
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] limIdx;
    limIdx = regAccess.addr - adc_monitor_pkg::OFS_LIMIT_BASE;
    s_d = s_q;
    s_d.req.start = 1'b0;
    s_d.req.abort = commActive;

    // Sequencer
    case (s_q.seq)
      adc_monitor_pkg::SEQ_IDLE: begin
        s_d.timer = '0;
        if (enable && !commActive) begin
          s_d.seq = adc_monitor_pkg::SEQ_START;
          if (single) begin
            s_d.req.channel = sel;
          end
        end
      end
      adc_monitor_pkg::SEQ_START: begin
        s_d.req.start = 1'b1;
        s_d.req.intRef = (s_q.req.channel <= adc_monitor_pkg::CH_EXT) ||
                         !s_q.ctrlA[adc_monitor_pkg::CTRLA_AINREF_BIT];
        s_d.timer = '0;
        s_d.seq = adc_monitor_pkg::SEQ_WAIT;
      end
      adc_monitor_pkg::SEQ_WAIT: begin
        s_d.timer = s_q.timer + TMR_W'(1);
        if (timeout) begin
          s_d.req.channel = nextCh;
          s_d.seq = adc_monitor_pkg::SEQ_START;
        end else if (convDone) begin
          s_d.seq = adc_monitor_pkg::SEQ_SETTLE;
        end
      end
      adc_monitor_pkg::SEQ_SETTLE: begin
        s_d.seq = adc_monitor_pkg::SEQ_START;
        if (store) begin
          s_d.results[s_q.req.channel] = avgResult;
          s_d.req.channel = nextCh;
        end
      end
      default: s_d.seq = adc_monitor_pkg::SEQ_IDLE;
    endcase
    // Serial traffic or disable drops any conversion in flight
    if (commActive || !enable) begin
      s_d.seq = adc_monitor_pkg::SEQ_IDLE;
      s_d.req.start = 1'b0;
    end

    // Register writes
    if (regAccess.wrEn) begin
      case (regAccess.addr)
        adc_monitor_pkg::OFS_CTRL_A: s_d.ctrlA = regAccess.wrData;
        adc_monitor_pkg::OFS_CTRL_B: s_d.ctrlB = regAccess.wrData;
        adc_monitor_pkg::OFS_MASK_A: s_d.maskA = regAccess.wrData;
        adc_monitor_pkg::OFS_MASK_B: s_d.maskB = regAccess.wrData;
        default: begin
          if (regAccess.addr >= adc_monitor_pkg::OFS_LIMIT_BASE &&
              regAccess.addr <= adc_monitor_pkg::OFS_LIMIT_LAST) begin
            if (limIdx[0]) begin
              s_d.limLo[limIdx[3:1]] = regAccess.wrData;
            end else begin
              s_d.limHi[limIdx[3:1]] = regAccess.wrData;
            end
          end
        end
      endcase
    end

    // Register reads; status reads clear, a same-cycle set still wins
    if (regAccess.rdEn) begin
      case (regAccess.addr)
        adc_monitor_pkg::OFS_STATUS_A: begin
          s_d.rdData = {2'h0, s_q.flags[6:1]};
          s_d.flags[6:1] = '0;
        end
        adc_monitor_pkg::OFS_STATUS_B: begin
          s_d.rdData = {7'h00, s_q.flags[0]};
          s_d.flags[0] = 1'b0;
        end
        adc_monitor_pkg::OFS_SUPPLY_LO: s_d.rdData = {6'h00, s_q.results[0][1:0]};
        adc_monitor_pkg::OFS_SUPPLY_HI: s_d.rdData = s_q.results[0][9:2];
        adc_monitor_pkg::OFS_TEMP_LO: s_d.rdData = {4'h0, s_q.results[2][1:0],
                                                    s_q.results[1][1:0]};
        adc_monitor_pkg::OFS_INPUT_LO: s_d.rdData = {s_q.results[6][1:0], s_q.results[5][1:0],
                                                     s_q.results[4][1:0], s_q.results[3][1:0]};
        adc_monitor_pkg::OFS_CTRL_A: s_d.rdData = s_q.ctrlA;
        adc_monitor_pkg::OFS_CTRL_B: s_d.rdData = s_q.ctrlB;
        adc_monitor_pkg::OFS_MASK_A: s_d.rdData = s_q.maskA;
        adc_monitor_pkg::OFS_MASK_B: s_d.rdData = s_q.maskB;
        default: begin
          s_d.rdData = 8'h00;
          if (regAccess.addr >= adc_monitor_pkg::OFS_VALUE_BASE &&
              regAccess.addr < adc_monitor_pkg::OFS_VALUE_BASE + 8'h06) begin
            s_d.rdData = s_q.results[3'(regAccess.addr - adc_monitor_pkg::OFS_VALUE_BASE)
                                     + 3'h1][9:2];
          end else if (regAccess.addr >= adc_monitor_pkg::OFS_LIMIT_BASE &&
                       regAccess.addr <= adc_monitor_pkg::OFS_LIMIT_LAST) begin
            s_d.rdData = limIdx[0] ? s_q.limLo[limIdx[3:1]] : s_q.limHi[limIdx[3:1]];
          end
        end
      endcase
    end

    // Out-of-limit flags, set after any clear so that the set wins
    if (store && (hiOut || loOut) && !maskVec[s_q.req.channel]) begin
      s_d.flags[s_q.req.channel] = 1'b1;
    end

    // Interrupt pin level follows the unmasked flags and polarity
    s_d.irqPin = polHigh ? anyUnmasked : !anyUnmasked;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= RESET_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign adcReq = s_q.req;
  assign irqOut = s_q.irqPin;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_irq_level: assert property (ce |=> irqOut == ($past(polHigh) ? $past(anyUnmasked)
                                                  : !$past(anyUnmasked)))
    else $error("interrupt pin level does not follow flags");

  a_irq_release: assert property (ce && !anyUnmasked && !polHigh |=> irqOut)
    else $error("interrupt pin held without unmasked flag");

  a_comm_abort: assert property (ce && commActive |=> !adcReq.start && adcReq.abort)
    else $error("conversion started during serial traffic");

  a_comm_restart: assert property (ce && s_q.seq == adc_monitor_pkg::SEQ_IDLE && enable
                                   && !commActive ##1 ce && !commActive && enable |=> adcReq.start)
    else $error("conversion not restarted after serial traffic");

  a_idle_disabled: assert property (ce && !enable |=> !adcReq.start)
    else $error("conversion started while monitoring disabled");

  a_single_channel: assert property (ce && s_q.seq == adc_monitor_pkg::SEQ_IDLE && single
                                     && enable && !commActive |=> adcReq.channel == $past(sel))
    else $error("single mode did not load selected channel");

  a_scan_order: assert property (ce && store && !single
                                 && adcReq.channel == adc_monitor_pkg::CH_INT
                                 |=> adcReq.channel == ($past(extMode) ? adc_monitor_pkg::CH_EXT
                                                        : adc_monitor_pkg::CH_AIN1))
    else $error("scan did not follow internal temperature correctly");

  a_supply_split: assert property (ce && regAccess.rdEn
                                   && regAccess.addr == adc_monitor_pkg::OFS_SUPPLY_HI
                                   |=> regRdData == $past(s_q.results[0][9:2]))
    else $error("supply high bits read wrong");

  a_flag_set: assert property (ce && store && (hiOut || loOut)
                               && !maskVec[s_q.req.channel] |=> s_q.flags[$past(adcReq.channel)])
    else $error("unmasked violation did not set flag");

  a_supply_ref: assert property (adcReq.start
                                 && adcReq.channel == adc_monitor_pkg::CH_SUPPLY |-> adcReq.intRef)
    else $error("supply converted without internal reference");

endmodule : adc_channel_monitor

/* testbench/conv_front_model.sv */
/*
  Analog front end model: answers each start pulse with one convDone pulse.
  Assumes the monitor's core clock and its request carrier.
*/
`timescale 1ns/1ps
module conv_front_model (
  input wire logic core_clk,
  input wire adc_monitor_pkg::adc_req_s adcReq,
  output logic convDone = 1'b0,
  output logic [9:0] convResult = 10'h000
);
  logic [3:0] busyCnt = 4'h0;
  logic [9:0] lastRes = 10'h000;
  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  // The result bus holds the complement of the last result between strobes, so a stale sample is never reused
  always @(posedge core_clk) begin
    convDone <= 1'b0;
    convResult <= ~lastRes;
    if (adcReq.abort) begin
      busyCnt <= 4'h0;
    end else if (adcReq.start) begin
      busyCnt <= 4'h5;
    end else if (busyCnt == 4'h1) begin
      busyCnt <= 4'h0;
      convDone <= 1'b1;
      convResult <= (adcReq.channel == 3'h0) ? 10'h2DB : 10'h100;
      lastRes <= (adcReq.channel == 3'h0) ? 10'h2DB : 10'h100;
    end else if (busyCnt != 4'h0) begin
      busyCnt <= busyCnt - 4'h1;
    end
  end
endmodule : conv_front_model

/* testbench/test_adc_channel_monitor.sv */
/*
  Self-checking bench: register tasks, supply monitoring and limit checks.
  Assumes the front end model above and short timeouts on the monitor.
*/
`timescale 1ns/1ps
module test_adc_channel_monitor;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic commActive = 1'b0;
  adc_monitor_pkg::reg_access_s regAccess = '0;
  logic [7:0] regRdData;
  adc_monitor_pkg::adc_req_s adcReq;
  logic convDone;
  logic [9:0] convResult;
  logic irqOut;
  int n_fail = 0;
  int n_compared = 0;
  always #2 core_clk = ~core_clk;
  adc_channel_monitor #(.INT_TIMEOUT_CYCLES(200), .EXT_TIMEOUT_CYCLES(150)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .regAccess(regAccess),
    .commActive(commActive), .regRdData(regRdData), .adcReq(adcReq),
    .convDone(convDone), .convResult(convResult), .irqOut(irqOut));
  conv_front_model FRONT (.core_clk(core_clk), .adcReq(adcReq), .convDone(convDone),
    .convResult(convResult));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // A transaction holds commActive over its strobe, as the serial front end does
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    commActive = 1'b1;
    regAccess = '{wrEn: wr, rdEn: ~wr, addr: a, wrData: d};
    @(negedge core_clk);
    regAccess = '0;
    commActive = 1'b0;
  endtask : access
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    access(1'b0, a, 8'h00);
    chk(what, exp, regRdData);
  endtask : rd
  task automatic settle();
    repeat (60) @(negedge core_clk);
  endtask : settle
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    rd(8'h19, 8'h00, "ctrlB reset");
    chk("irq idle", 8'h01, {7'h00, irqOut});
    access(1'b1, 8'h19, 8'h30);
    access(1'b1, 8'h18, 8'h01);
    settle();
    rd(8'h06, 8'hB6, "supply hi");
    rd(8'h03, 8'h03, "supply lo");
    rd(8'h01, 8'h00, "statusB");
    access(1'b1, 8'h2C, 8'hB6);
    settle();
    chk("irq equal hi", 8'h01, {7'h00, irqOut});
    access(1'b1, 8'h2D, 8'hB6);
    settle();
    chk("irq low", 8'h00, {7'h00, irqOut});
    access(1'b1, 8'h1D, 8'h01);
    rd(8'h01, 8'h01, "statusB flag");
    rd(8'h01, 8'h00, "statusB clear");
    settle();
    chk("irq masked", 8'h01, {7'h00, irqOut});
    access(1'b1, 8'h1D, 8'h00);
    access(1'b1, 8'h18, 8'h09);
    settle();
    chk("irq high", 8'h01, {7'h00, irqOut});
    access(1'b1, 8'h19, 8'h20);
    access(1'b1, 8'h37, 8'h40);
    settle();
    settle();
    rd(8'h07, 8'h40, "int temp value");
    rd(8'h08, 8'h40, "ext temp value");
    rd(8'h00, 8'h10, "statusA flag");
    rd(8'h40, 8'h00, "unmapped");
    stop_test();
  end
  // A hung sequence is cut short here and counted as a mismatch
  initial begin
    repeat (20000) @(negedge core_clk);
    n_fail++;
    stop_test();
  end
endmodule : test_adc_channel_monitor
